// *** flyback_core_asserts.sv ***
module flyback_core_asserts
  import flyback_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Comparator and supervisor inputs
  input wire logic power_down_reset_level,
  input wire logic cs_peak_limit,
  input wire logic disable_threshold,
  input wire logic supply_overvolt,
  input wire logic die_overtemp,
  input wire logic line_brownout_level,
  // Bus handshake
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // Gate
  input wire logic gate_drive
);
  logic [9:0] hi_cnt;
  logic [9:0] gap;

  // Length of the present gate pulse
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) hi_cnt <= 10'h000;
    else hi_cnt <= gate_drive ? hi_cnt + 10'h001 : 10'h000;
  end

  // Saturates so the first pulse after reset never looks early
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) gap <= 10'h3ff;
    else if ($rose(gate_drive)) gap <= 10'h001;
    else if (gap != 10'h3ff) gap <= gap + 10'h001;
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence sov_trip;
    supply_overvolt [*5];
  endsequence
  sequence no_pdr;
    !power_down_reset_level [*8];
  endsequence

  a_disable_kill: assert property (disable_threshold [*5] |-> !gate_drive)
    else $error("gate on under disable");
  a_sov_stop: assert property (sov_trip |-> !gate_drive)
    else $error("gate on under supply overvoltage");
  a_sov_latch: assert property (sov_trip ##1 no_pdr |-> !gate_drive)
    else $error("supply overvoltage latch lost");
  a_dot_hold: assert property (die_overtemp [*5] |-> !gate_drive)
    else $error("gate on under die overtemperature");
  a_brown_hold: assert property (line_brownout_level [*5] |-> !gate_drive)
    else $error("gate on under brownout");
  a_duty_cap: assert property (hi_cnt <= 10'(PERIOD_MAX * DUTY_MAX_PCT / 100 + 1))
    else $error("pulse longer than duty limit");
  a_blank_keep: assert property ($rose(gate_drive) && !disable_threshold && !supply_overvolt
    && !die_overtemp |=> gate_drive [*2])
    else $error("pulse cut inside blanking");
  a_peak_cut: assert property (cs_peak_limit [*5] |-> !gate_drive || hi_cnt < 10'(BLANK_CYC + 6))
    else $error("pulse not ended at peak limit");
  a_period_min: assert property ($rose(gate_drive) |-> gap >= 10'(PERIOD_MIN))
    else $error("switching period too short");
  a_wait_one: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
    else $error("bus answer not after one wait cycle");
  a_wait_short: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
endmodule // flyback_core_asserts

bind flyback_pwm_protection_core flyback_core_asserts chk_i (.*);

// *** flyback_pkg.sv ***
package flyback_pkg;

  // Clock
  localparam int unsigned CLK_HZ = 25_000_000;

  // Switching period: 65 kHz nominal, +-6 kHz spread
  localparam int unsigned FSW_NOM_HZ     = 65_000;
  localparam int unsigned FSW_SPREAD_HZ  = 6_000;
  localparam int unsigned PERIOD_NOM     = CLK_HZ / FSW_NOM_HZ;
  localparam int unsigned PERIOD_MIN     = CLK_HZ / (FSW_NOM_HZ + FSW_SPREAD_HZ);
  localparam int unsigned PERIOD_MAX     = CLK_HZ / (FSW_NOM_HZ - FSW_SPREAD_HZ);
  localparam int unsigned SPREAD_STEP    = 1;

  // Duty limit in percent
  localparam int unsigned DUTY_MAX_PCT   = 80;

  // Blanking 300 ns, rounded up
  localparam int unsigned BLANK_NS       = 300;
  localparam int unsigned BLANK_CYC      = (BLANK_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  // Qualification times
  localparam int unsigned OPP_DELAY_MS   = 320;
  localparam int unsigned OPP_CYC        = OPP_DELAY_MS * (CLK_HZ / 1000);
  localparam int unsigned OCP_TIME_MS    = 1700;
  localparam int unsigned OCP_CYC        = OCP_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned EOT_TIME_MS    = 40;
  localparam int unsigned EOT_CYC        = EOT_TIME_MS * (CLK_HZ / 1000);

  // Aux winding counts in switching cycles
  localparam int unsigned AUX_OV_CYCLES  = 8;
  localparam int unsigned AUX_UV_SKIP    = 1;

  // Avalon register offsets (byte addresses)
  localparam logic [4:0] REG_CTRL        = 5'h00;
  localparam logic [4:0] REG_STATE       = 5'h04;
  localparam logic [4:0] REG_IRQ_STATUS  = 5'h08;
  localparam logic [4:0] REG_IRQ_CLEAR   = 5'h0c;
  localparam logic [4:0] REG_IRQ_ENABLE  = 5'h10;

  // Control bits
  localparam int unsigned CTRL_SPREAD_EN = 0;
  localparam int unsigned CTRL_CS_LOW    = 1;
  localparam logic [1:0] CTRL_RESET      = 2'h1;

  // Event bit positions (status, clear, enable share layout)
  localparam int unsigned EV_OPP     = 0;
  localparam int unsigned EV_OCP     = 1;
  localparam int unsigned EV_SOV     = 2;
  localparam int unsigned EV_AOV     = 3;
  localparam int unsigned EV_EOT     = 4;
  localparam int unsigned EV_DOT     = 5;
  localparam int unsigned EV_UVSKIP  = 6;
  localparam int unsigned EV_DISABLE = 7;
  localparam int unsigned EV_W       = 8;

  localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;

endpackage : flyback_pkg

// *** flyback_pwm_protection_core.sv ***
// Summary of operation
// - Ignore peak and over-loop current-sense comparators for 300 ns after each gate rising edge.
// - Gate high time never exceeds 80 percent of the switching period.
// - Switching oscillator at 65 kHz, swept within plus or minus 6 kHz.
// - End pulse cycle by cycle when current reaches the peak limit.
// - End pulse when sensed current exceeds a quarter of loop voltage.
// - Disable comparator forces gate low at once; release resumes switching.
// - Loop voltage above over-power level longer than delay latches gate off.
// - Latched faults hold gate off until power-down reset clears them.
// - Accumulated over-current time beyond 1.7 s latches gate off.
// - Supply over-voltage stops switching at once and latches.
// - Die over-temperature holds gate off unlatched until hysteresis release.
// - Aux under-voltage sampled in gate-off; trip skips one cycle, no latch.
// - Aux over-voltage comparator evaluated during gate-off of each cycle.
// - Aux over-voltage seen 8 consecutive cycles latches gate off.
// - Gate-off current-sense over external temperature level for 40 ms latches.
// - Line brown-out keeps gate off until brown-in, regardless of supply.
module flyback_pwm_protection_core
  import flyback_pkg::*;
#(
  parameter int unsigned OPP_COUNT = OPP_CYC,
  parameter int unsigned OCP_COUNT = OCP_CYC,
  parameter int unsigned EOT_COUNT = EOT_CYC
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // Supply supervision (power-down reset clears latches)
  input  wire logic        power_down_reset_level,
  // Comparator inputs, asynchronous
  input  wire logic        cs_peak_limit,
  input  wire logic        cs_over_loop,
  input  wire logic        cs_ocp_level,
  input  wire logic        cs_ext_temp,
  input  wire logic        disable_threshold,
  input  wire logic        loop_over_power,
  input  wire logic        supply_overvolt,
  input  wire logic        die_overtemp,
  input  wire logic        aux_winding_sense_uv,
  input  wire logic        aux_winding_sense_ov,
  input  wire logic        line_brownout_level,
  input  wire logic        line_brownin_level,
  // Gate drive
  output logic             gate_drive,
  output logic             cs_otp_level_sel,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Interrupt
  output logic             irq
);

  if (OPP_COUNT < 1 || OCP_COUNT < 1 || EOT_COUNT < 1) begin : g_count_check
    $error("Qualification counts must be at least one");
  end

  localparam int unsigned NSYNC = 13;

  // Two-flop synchronisers for every comparator
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] sync1;
  logic [NSYNC-1:0] sync2;

  assign raw_in = {power_down_reset_level, line_brownin_level, line_brownout_level, aux_winding_sense_ov,
                   aux_winding_sense_uv, die_overtemp, supply_overvolt, loop_over_power,
                   disable_threshold, cs_ext_temp, cs_ocp_level, cs_over_loop, cs_peak_limit};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
          sync1[gi] <= 1'b0;
          sync2[gi] <= 1'b0;
        end else begin
          sync1[gi] <= raw_in[gi];
          sync2[gi] <= sync1[gi];
        end
      end
    end
  endgenerate

  logic s_peak, s_loop, s_ocp, s_eot, s_dis, s_opp, s_sov, s_dot, s_auv, s_aov, s_bo, s_bi, s_pdr;
  assign {s_pdr, s_bi, s_bo, s_aov, s_auv, s_dot, s_sov, s_opp, s_dis, s_eot, s_ocp, s_loop, s_peak} = sync2;

  // Control register
  logic [1:0] ctrl;

  // Oscillator with triangular frequency sweep
  logic [15:0] period_len;
  logic [15:0] phase;
  logic        sweep_up;
  logic        cycle_start;
  logic [15:0] duty_limit;

  assign cycle_start = (phase == 16'h0000);
  assign duty_limit  = 16'((32'(period_len) * DUTY_MAX_PCT) / 100);

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      phase <= 16'h0000;
    end else if (phase >= period_len - 16'h0001) begin
      phase <= 16'h0000;
    end else begin
      phase <= phase + 16'h0001;
    end
  end

  // Period steps once per cycle between the spread bounds; trades exact 65 kHz for EMI spreading
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      period_len <= 16'(PERIOD_NOM);
      sweep_up   <= 1'b1;
    end else if (cycle_start) begin
      if (!ctrl[CTRL_SPREAD_EN]) begin
        period_len <= 16'(PERIOD_NOM);
      end else if (sweep_up) begin
        if (period_len >= 16'(PERIOD_MAX)) begin
          sweep_up <= 1'b0;
        end else begin
          period_len <= period_len + 16'(SPREAD_STEP);
        end
      end else begin
        if (period_len <= 16'(PERIOD_MIN)) begin
          sweep_up <= 1'b1;
        end else begin
          period_len <= period_len - 16'(SPREAD_STEP);
        end
      end
    end
  end

  // Gate and blanking
  logic [7:0] blank_cnt;
  logic       blanking;
  logic       gate_q;

  assign blanking = (blank_cnt != 8'h00);

  // Fault latches and soft conditions
  logic       latch_opp, latch_ocp, latch_sov, latch_aov, latch_eot;
  logic       any_latch;
  logic       skip_next;
  logic       skipping;
  logic       brown_hold;
  logic       inhibit;
  logic       latch_near;

  assign any_latch = latch_opp | latch_ocp | latch_sov | latch_aov | latch_eot;
  assign inhibit   = any_latch | s_dis | s_dot | brown_hold | s_sov;

  logic term;
  assign term = (!blanking && (s_peak || s_loop))
              || (phase >= duty_limit - 16'h0001);

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      gate_q    <= 1'b0;
      blank_cnt <= 8'h00;
    end else if (inhibit) begin
      gate_q    <= 1'b0;
      blank_cnt <= 8'h00;
    end else if (cycle_start && !skipping && !latch_near) begin
      gate_q    <= 1'b1;
      blank_cnt <= 8'(BLANK_CYC);
    end else begin
      if (gate_q && term) begin
        gate_q <= 1'b0;
      end
      if (blanking) begin
        blank_cnt <= blank_cnt - 8'h01;
      end
    end
  end

  // Gate output from flop; also gated combinationally would break the flop rule,
  // so inhibit acts one cycle after the synchronised comparator.
  assign gate_drive = gate_q;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cs_otp_level_sel <= 1'b0;
    end else begin
      cs_otp_level_sel <= ctrl[CTRL_CS_LOW];
    end
  end

  // Brown-out: hold until brown-in seen
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      brown_hold <= 1'b1;
    end else if (s_bo) begin
      brown_hold <= 1'b1;
    end else if (s_bi) begin
      brown_hold <= 1'b0;
    end
  end

  // Over-power qualification
  logic [31:0] opp_cnt;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      opp_cnt <= 32'h0;
    end else if (!s_opp) begin
      opp_cnt <= 32'h0;
    end else if (opp_cnt < OPP_COUNT) begin
      opp_cnt <= opp_cnt + 32'h1;
    end
  end

  // Over-current accumulates; never cleared except by power-down
  logic [31:0] ocp_cnt;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ocp_cnt <= 32'h0;
    end else if (s_pdr) begin
      ocp_cnt <= 32'h0;
    end else if (s_ocp && ocp_cnt < OCP_COUNT) begin
      ocp_cnt <= ocp_cnt + 32'h1;
    end
  end

  // External temperature during gate-off
  logic [31:0] eot_cnt;
  logic        eot_cond;
  assign eot_cond = s_eot && !gate_q;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      eot_cnt <= 32'h0;
    end else if (gate_q) begin
      eot_cnt <= eot_cnt;
    end else if (!eot_cond) begin
      eot_cnt <= 32'h0;
    end else if (eot_cnt < EOT_COUNT) begin
      eot_cnt <= eot_cnt + 32'h1;
    end
  end

  // Aux winding: sample in gate-off, judge at cycle start
  logic       aov_seen, auv_seen;
  logic [3:0] aov_run;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      aov_seen <= 1'b0;
      auv_seen <= 1'b0;
    end else if (cycle_start) begin
      aov_seen <= 1'b0;
      auv_seen <= 1'b0;
    end else if (!gate_q && !blanking) begin
      if (s_aov) aov_seen <= 1'b1;
      if (s_auv) auv_seen <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      aov_run <= 4'h0;
    end else if (cycle_start) begin
      if (!aov_seen) begin
        aov_run <= 4'h0;
      end else if (aov_run < 4'(AUX_OV_CYCLES)) begin
        aov_run <= aov_run + 4'h1;
      end
    end
  end

  // An over-power or aux over-voltage latch due within two edges would cut a fresh pulse inside blanking, so hold it off
  assign latch_near = (s_opp && opp_cnt >= OPP_COUNT - 1)
                   || (aov_seen && aov_run >= 4'(AUX_OV_CYCLES - 1));

  // Skip exactly the next cycle after an under-voltage trip
  assign skipping = auv_seen && (AUX_UV_SKIP != 0);
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      skip_next <= 1'b0;
    end else if (cycle_start) begin
      skip_next <= skipping;
    end
  end

  // Fault latches: only the power-down reset releases them
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      latch_opp <= 1'b0;
      latch_ocp <= 1'b0;
      latch_sov <= 1'b0;
      latch_aov <= 1'b0;
      latch_eot <= 1'b0;
    end else if (s_pdr) begin
      latch_opp <= 1'b0;
      latch_ocp <= 1'b0;
      latch_sov <= 1'b0;
      latch_aov <= 1'b0;
      latch_eot <= 1'b0;
    end else begin
      if (opp_cnt >= OPP_COUNT) latch_opp <= 1'b1;
      if (ocp_cnt >= OCP_COUNT) latch_ocp <= 1'b1;
      if (s_sov) latch_sov <= 1'b1;
      if (aov_run >= 4'(AUX_OV_CYCLES)) latch_aov <= 1'b1;
      if (eot_cnt >= EOT_COUNT) latch_eot <= 1'b1;
    end
  end

  // Interrupt events: rising edges of fault conditions
  logic [EV_W-1:0] ev_now, ev_prev, ev_pulse;
  logic [EV_W-1:0] irq_status, irq_enable;

  always_comb begin
    ev_now             = '0;
    ev_now[EV_OPP]     = latch_opp;
    ev_now[EV_OCP]     = latch_ocp;
    ev_now[EV_SOV]     = latch_sov;
    ev_now[EV_AOV]     = latch_aov;
    ev_now[EV_EOT]     = latch_eot;
    ev_now[EV_DOT]     = s_dot;
    ev_now[EV_UVSKIP]  = skip_next;
    ev_now[EV_DISABLE] = s_dis;
  end
  assign ev_pulse = ev_now & ~ev_prev;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ev_prev <= '0;
    end else begin
      ev_prev <= ev_now;
    end
  end

  // Avalon slave: one wait cycle, answer on the second edge
  logic       acc_done;
  logic       wr_go;
  logic [EV_W-1:0] clr_bits;

  assign wr_go    = avs_write && acc_done;
  assign clr_bits = (wr_go && avs_address == REG_IRQ_CLEAR) ? avs_writedata[EV_W-1:0] : '0;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_status <= '0;
    end else begin
      irq_status <= (irq_status & ~clr_bits) | ev_pulse;          // set wins over clear
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl       <= CTRL_RESET;
      irq_enable <= '0;
    end else if (wr_go) begin
      if (avs_address == REG_CTRL) ctrl <= avs_writedata[1:0];
      if (avs_address == REG_IRQ_ENABLE) irq_enable <= avs_writedata[EV_W-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_enable);
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_done        <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0;
    end else if ((avs_read || avs_write) && !acc_done) begin
      acc_done        <= 1'b1;
      avs_waitrequest <= 1'b0;
      unique case (avs_address)
        REG_CTRL:       avs_readdata <= {30'h0, ctrl};
        REG_STATE:      avs_readdata <= {23'h0, brown_hold, gate_q, skip_next, latch_eot,
                                         latch_aov, latch_sov, latch_ocp, latch_opp, 1'b0};
        REG_IRQ_STATUS: avs_readdata <= {24'h0, irq_status};
        REG_IRQ_ENABLE: avs_readdata <= {24'h0, irq_enable};
        default:        avs_readdata <= READ_UNMAPPED;
      endcase
    end else begin
      acc_done        <= 1'b0;
      avs_waitrequest <= 1'b1;
    end
  end

endmodule // flyback_pwm_protection_core

// *** flyback_switch_model.sv ***
module flyback_switch_model (
  // Clock and gate
  input wire logic       ref_clk,
  input wire logic       gate_drive,
  // Scenario knobs: on-time counts where the current crosses each level
  input wire logic [9:0] peak_at,
  input wire logic [9:0] loop_at,
  input wire logic [9:0] ocp_at,
  input wire logic       ntc_hot,
  input wire logic       out_short,
  input wire logic       out_over,
  // Comparators
  output logic           cs_peak_limit,
  output logic           cs_over_loop,
  output logic           cs_ocp_level,
  output logic           cs_ext_temp,
  output logic           aux_winding_sense_uv,
  output logic           aux_winding_sense_ov
);
  logic [9:0] on_t;

  // Switch current ramps only while the gate is on
  always_ff @(posedge ref_clk) begin
    on_t <= gate_drive ? on_t + 10'h001 : 10'h000;
  end

  assign cs_peak_limit = gate_drive && on_t >= peak_at;
  assign cs_over_loop = gate_drive && on_t >= loop_at;
  assign cs_ocp_level = gate_drive && on_t >= ocp_at;
  // Thermistor and winding reflect the real levels only in the off time
  assign cs_ext_temp = !gate_drive && ntc_hot;
  assign aux_winding_sense_uv = !gate_drive && out_short;
  assign aux_winding_sense_ov = !gate_drive && out_over;
endmodule // flyback_switch_model

// *** tb_top.sv ***
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import flyback_pkg::*;
  localparam int PMAX = PERIOD_MAX;
  logic ref_clk = 1'h0, reset_n = 1'h0, power_down_reset_level = 1'h0;
  logic disable_threshold = 1'h0, loop_over_power = 1'h0, supply_overvolt = 1'h0, die_overtemp = 1'h0;
  logic line_brownout_level = 1'h1, line_brownin_level = 1'h0;
  logic ntc_hot = 1'h0, out_short = 1'h0, out_over = 1'h0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'h0, avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0, d, v;
  logic [9:0] peak_at = 10'h3ff, loop_at = 10'h3ff, ocp_at = 10'h3ff;
  wire cs_peak_limit, cs_over_loop, cs_ocp_level, cs_ext_temp, aux_winding_sense_uv, aux_winding_sense_ov;
  wire gate_drive, cs_otp_level_sel, avs_waitrequest, irq;
  wire [31:0] avs_readdata;
  int err_count = 0, comparisons = 0, cycles = 0, seed = 60, hi, per, g;

  always #20 ref_clk = ~ref_clk;

  // Short qualification counts keep the run brief
  flyback_pwm_protection_core #(.OPP_COUNT(50), .OCP_COUNT(50), .EOT_COUNT(50)) DUT (.*);
  flyback_switch_model sw (.*);

  task wrap_up;
    $display("mismatches %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 80000) begin
      err_count++;
      wrap_up;
    end
  end

  task cyc(int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task chk(logic [31:0] got, logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task rng(int got, int lo, int up);
    chk(32'(got), 32'(got < lo ? lo : (got > up ? up : got)));
  endtask

  // Holds the request until waitrequest is sampled low; only the bench timeout ends a hung wait
  task automatic bus(logic [4:0] a, logic w, logic [31:0] wd);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= wd;
    do begin
      @(posedge ref_clk);
    end while (avs_waitrequest !== 1'h0);
    d = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    @(posedge ref_clk);
  endtask

  task automatic runs(logic on);
    int r = 0;
    logic p = gate_drive;
    repeat (2 * PMAX + 10) begin
      @(posedge ref_clk);
      if (gate_drive === 1'h1 && p === 1'h0) r++;
      p = gate_drive;
    end
    chk(32'(r != 0), 32'(on));
  endtask

  task automatic fall;
    int t = 0;
    while (gate_drive !== 1'h1 && t < 2000) begin @(posedge ref_clk); t++; end
    while (gate_drive === 1'h1 && t < 2000) begin @(posedge ref_clk); t++; end
    if (t >= 2000) err_count++;
  endtask

  task automatic meas;
    int t = 0;
    hi = 0;
    while (gate_drive !== 1'h0 && t < 2000) begin @(posedge ref_clk); t++; end
    while (gate_drive !== 1'h1 && t < 2000) begin @(posedge ref_clk); t++; end
    while (gate_drive === 1'h1 && t < 2000) begin @(posedge ref_clk); t++; hi++; end
    per = hi;
    while (gate_drive === 1'h0 && t < 2000) begin @(posedge ref_clk); t++; per++; end
    if (t >= 2000) err_count++;
  endtask

  task automatic after(int b, logic lat);
    cyc(5);
    bus(REG_IRQ_STATUS, 1'h0, 32'h0);
    chk(32'(d[b]), 32'h1);
    bus(REG_IRQ_CLEAR, 1'h1, 32'hff);
    if (lat) begin
      runs(1'h0);
      power_down_reset_level <= 1'h1;
      cyc(4);
      power_down_reset_level <= 1'h0;
      cyc(4);
    end
    runs(1'h1);
  endtask

  initial begin
    cyc(4);
    reset_n <= 1'h1;
    cyc(1);
    bus(REG_CTRL, 1'h0, 32'h0);
    chk(d, 32'(CTRL_RESET));
    bus(5'h14, 1'h1, 32'hffffffff);
    bus(5'h14, 1'h0, 32'h0);
    chk(d, READ_UNMAPPED);
    bus(REG_IRQ_CLEAR, 1'h0, 32'h0);
    chk(d, 32'h0);
    for (int i = 0; i < 3; i++) begin
      v = $random(seed);
      bus(REG_IRQ_ENABLE, 1'h1, v);
      bus(REG_IRQ_ENABLE, 1'h0, 32'h0);
      chk(d, v & ((32'h1 << EV_W) - 32'h1));
    end
    runs(1'h0);
    line_brownout_level <= 1'h0;
    line_brownin_level <= 1'h1;
    runs(1'h1);
    meas;
    rng(hi, PERIOD_MIN * DUTY_MAX_PCT / 100 - 1, PMAX * DUTY_MAX_PCT / 100 + 1);
    rng(per, PERIOD_MIN, PMAX + 1);
    peak_at <= 10'h064;
    meas;
    rng(hi, 100, 106);
    peak_at <= 10'h000;
    meas;
    rng(hi, BLANK_CYC, BLANK_CYC + 5);
    peak_at <= 10'h3ff;
    loop_at <= 10'h03c;
    meas;
    rng(hi, 60, 66);
    loop_at <= 10'h3ff;
    // Unmasked then masked disable event
    bus(REG_IRQ_ENABLE, 1'h1, 32'h1 << EV_DISABLE);
    disable_threshold <= 1'h1;
    cyc(5);
    chk(32'(gate_drive), 32'h0);
    cyc(3);
    chk(32'(irq), 32'h1);
    disable_threshold <= 1'h0;
    bus(REG_IRQ_CLEAR, 1'h1, 32'hff);
    cyc(2);
    chk(32'(irq), 32'h0);
    bus(REG_IRQ_ENABLE, 1'h1, 32'h0);
    disable_threshold <= 1'h1;
    cyc(8);
    chk(32'(irq), 32'h0);
    disable_threshold <= 1'h0;
    after(EV_DISABLE, 1'h0);
    die_overtemp <= 1'h1;
    cyc(4);
    runs(1'h0);
    die_overtemp <= 1'h0;
    after(EV_DOT, 1'h0);
    supply_overvolt <= 1'h1;
    cyc(5);
    supply_overvolt <= 1'h0;
    after(EV_SOV, 1'h1);
    repeat (2) begin
      loop_over_power <= 1'h1;
      cyc(30);
      loop_over_power <= 1'h0;
      cyc(5);
    end
    bus(REG_IRQ_STATUS, 1'h0, 32'h0);
    chk(32'(d[EV_OPP]), 32'h0);
    loop_over_power <= 1'h1;
    cyc(80);
    loop_over_power <= 1'h0;
    after(EV_OPP, 1'h1);
    // Spread off: a fixed period makes the per-pulse over-current time predictable
    bus(REG_CTRL, 1'h1, 32'h2);
    cyc(1);
    chk(32'(cs_otp_level_sel), 32'h1);
    repeat (3) begin
      fall;
      ntc_hot <= 1'h1;
      cyc(20);
      ntc_hot <= 1'h0;
    end
    bus(REG_IRQ_STATUS, 1'h0, 32'h0);
    chk(32'(d[EV_EOT]), 32'h0);
    fall;
    ntc_hot <= 1'h1;
    cyc(100);
    ntc_hot <= 1'h0;
    after(EV_EOT, 1'h1);
    // Roughly 26 over-threshold cycles per pulse
    ocp_at <= 10'h118;
    fall;
    bus(REG_IRQ_STATUS, 1'h0, 32'h0);
    chk(32'(d[EV_OCP]), 32'h0);
    cyc(3 * PMAX);
    ocp_at <= 10'h3ff;
    after(EV_OCP, 1'h1);
    out_over <= 1'h1;
    repeat (6) fall;
    bus(REG_IRQ_STATUS, 1'h0, 32'h0);
    chk(32'(d[EV_AOV]), 32'h0);
    cyc(4 * PMAX);
    out_over <= 1'h0;
    after(EV_AOV, 1'h1);
    fall;
    out_short <= 1'h1;
    cyc(10);
    out_short <= 1'h0;
    g = 10;
    while (gate_drive !== 1'h1 && g < 2000) begin @(posedge ref_clk); g++; end
    rng(g, PERIOD_MIN, 3 * PMAX);
    after(EV_UVSKIP, 1'h0);
    wrap_up;
  end
endmodule // tb_top
